/* common/ssw_pkg.sv */
// constants and types shared by the supervisor and its watchdog
// assumes a single free-running 10 MHz timebase
package ssw_pkg;
  // ****************************************
  // timebase
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
  // ****************************************
  // timeouts, least times round up to whole ticks
  // ****************************************
  localparam int RST_TIMEOUT_MS = 200;
  localparam int WD_TIMEOUT_MS = 1600;
  localparam int RST_TICKS = (RST_TIMEOUT_MS * 1000 + TICK_US - 1) / TICK_US;
  localparam int WD_TICKS = (WD_TIMEOUT_MS * 1000 + TICK_US - 1) / TICK_US;
  // ****************************************
  // input synchroniser layout
  // ****************************************
  localparam int IN_W = 5;
  localparam int IN_SUPPLY = 0;
  localparam int IN_MR = 1;
  localparam int IN_PF = 2;
  localparam int IN_KICK = 3;
  localparam int IN_FLOAT = 4;
  // safe levels: supply low, no manual reset, no power fail, floating kick
  localparam logic [4:0] SYNC_RST = 5'h17;
  typedef enum logic [1:0] {
    SSW_HOLD = 2'b00,
    SSW_TIMEOUT = 2'b01,
    SSW_RUN = 2'b10
  } ssw_rst_e;
endpackage

/* common/ssw_wd_if.sv */
// carrier between the supervisor core and its watchdog timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ssw_wd_if;
  logic tick;
  logic hold;
  logic kick;
  logic floating;
  logic timeout;
  modport ctl (output tick, output hold, output kick, output floating, input timeout);
  modport wdog (input tick, input hold, input kick, input floating, output timeout);
endinterface // ssw_wd_if

/* design/ssw_watchdog.sv */
// watchdog timer counting prescaled ticks between kick transitions
// assumes kick and floating are already synchronised to mclk
`timescale 1ns/1ps
module ssw_watchdog
  import ssw_pkg::*;
#(
  parameter int WD_LIMIT = WD_TICKS,
  parameter int CNT_W = 12
) (
  input wire logic mclk,
  input wire logic reset_n,
  ssw_wd_if.wdog wd
);
  logic kick_d_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic timeout_r;
  logic timeout_nxt;
  logic kick_edge;
  logic clr;
  logic force_clr;
  logic last_tick;

  // ****************************************
  // clear and count
  // ****************************************
  // either edge clears
  assign kick_edge = (wd.kick ^ kick_d_r) & ~wd.floating;
  // held clear in reset; floating disables
  assign clr = wd.hold | kick_edge | wd.floating;
  assign last_tick = wd.tick && (cnt_r == CNT_W'(WD_LIMIT - 1));
  assign cnt_nxt = clr ? '0 : ((wd.tick && !timeout_r) ? cnt_r + 1'b1 : cnt_r);
  assign force_clr = wd.hold | wd.floating;
  // expiry; sticks until cleared
  // kick on the expiring tick loses: the period has already run out
  assign timeout_nxt = force_clr ? 1'b0 : (last_tick | (timeout_r & ~kick_edge));
  assign wd.timeout = timeout_r;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      kick_d_r <= 1'b0;
      cnt_r <= '0;
      timeout_r <= 1'b0;
    end else begin
      kick_d_r <= wd.kick;
      cnt_r <= cnt_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  expiry_sets_a: assert property (last_tick && !force_clr |=> timeout_r)
    else $error("watchdog did not expire on last tick");
  timeout_sticks_a: assert property (timeout_r && !clr |=> timeout_r)
    else $error("watchdog timeout dropped without clear");
  kick_clears_a: assert property (kick_edge && !last_tick |=> cnt_r == '0 && !timeout_r)
    else $error("kick edge did not clear watchdog");
  reset_clears_a: assert property (wd.hold |=> cnt_r == '0 && !timeout_r)
    else $error("watchdog counted during reset");
  float_disables_a: assert property (wd.floating |=> !timeout_r)
    else $error("watchdog timed out while floating");
  expiry_seen_c: cover property (!timeout_r ##1 timeout_r);
endmodule // ssw_watchdog

/* design/ssw_top.sv */
// supply supervisor: reset generator, watchdog and power-fail pass-through
// assumes comparator results arrive as asynchronous digital levels
//
// Summary of operation
// - reset held while supply is low
// - reset held 200 ms after supply recovers
// - active-high reset is inverse of reset
// - manual reset bounces absorbed by the timeout
// - manual low resets, 200 ms after release
// - watchdog alarm after 1.6 s without kick
// - alarm stays low until timer cleared
// - any kick edge clears the watchdog, except one on the expiring tick
// - watchdog held cleared during reset
// - supply low forces watchdog alarm low
// - floating kick input disables watchdog timeout
// - kick input has low, high, floating
// - power-fail flag follows comparator result
// - watchdog timeout never asserts reset itself
`timescale 1ns/1ps
module ssw_top
  import ssw_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int RST_LIMIT = RST_TICKS,
  parameter int WD_LIMIT = WD_TICKS,
  parameter int PRE_W = 16,
  parameter int RCNT_W = 12,
  parameter int WCNT_W = 12
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic supply_low_in,
  input wire logic manual_reset_n,
  input wire logic powerfail_sense_in,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_float_in,
  output logic sys_reset_n,
  output logic sys_reset,
  output logic watchdog_alarm_n,
  output logic powerfail_flag_n
);
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] filt;
  logic supply_low_f;
  logic mr_n_f;
  logic pf_f;
  logic hold_req;
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic tick;
  ssw_rst_e state_r;
  ssw_rst_e state_nxt;
  logic [RCNT_W-1:0] rcnt_r;
  logic [RCNT_W-1:0] rcnt_nxt;
  logic rst_done;
  logic sys_reset_n_r;
  logic sys_reset_r;
  logic alarm_n_r;
  logic pf_n_r;
  ssw_wd_if wd ();

  // ****************************************
  // input synchronisers
  // ****************************************
  // three stages, settle on agreement
  assign raw_in = {watchdog_float_in, watchdog_kick_in, powerfail_sense_in,
                   manual_reset_n, supply_low_in};

  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_sync
      logic [2:0] sh_r;
      logic f_r;
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          sh_r <= {3{SYNC_RST[gi]}};
          f_r <= SYNC_RST[gi];
        end else begin
          sh_r <= {sh_r[1:0], raw_in[gi]};
          // first stage feeds only the second; filter looks at stages two and three
          if (sh_r[1] == sh_r[2]) begin
            f_r <= sh_r[2];
          end
        end
      end
      assign filt[gi] = f_r;
    end
  endgenerate

  assign supply_low_f = filt[IN_SUPPLY];
  assign mr_n_f = filt[IN_MR];
  assign pf_f = filt[IN_PF];

  // ****************************************
  // tick prescaler
  // ****************************************
  // restarted during hold so the reset timeout is exact, not one tick short
  assign hold_req = supply_low_f | ~mr_n_f;
  assign tick = (pre_r == PRE_W'(TICK_CYC - 1));
  assign pre_nxt = (hold_req || tick) ? '0 : pre_r + 1'b1;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // ****************************************
  // reset generator
  // ****************************************
  assign rst_done = tick && (rcnt_r == RCNT_W'(RST_LIMIT - 1));

  // hold while low; manual low holds too
  // a bounce during timeout returns to hold and restarts the count
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SSW_HOLD: begin
        if (!hold_req) begin
          state_nxt = SSW_TIMEOUT;
        end
      end
      SSW_TIMEOUT: begin
        if (hold_req) begin
          state_nxt = SSW_HOLD;
        end else if (rst_done) begin
          state_nxt = SSW_RUN;
        end
      end
      SSW_RUN: begin
        if (hold_req) begin
          state_nxt = SSW_HOLD;
        end
      end
      default: begin
        state_nxt = SSW_HOLD;
      end
    endcase
  end

  // timeout counted only while released inputs stay quiet
  assign rcnt_nxt = (state_r != SSW_TIMEOUT || hold_req) ? '0 :
                    (tick ? rcnt_r + 1'b1 : rcnt_r);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_r <= SSW_HOLD;
      rcnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      rcnt_r <= rcnt_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // reset depends on supply and manual input only
  // both reset outputs from one next value
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sys_reset_n_r <= 1'b0;
      sys_reset_r <= 1'b1;
    end else begin
      sys_reset_n_r <= (state_nxt == SSW_RUN);
      sys_reset_r <= (state_nxt != SSW_RUN);
    end
  end

  // low line forces alarm; released when supply recovers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      alarm_n_r <= 1'b0;
      pf_n_r <= 1'b1;
    end else begin
      alarm_n_r <= ~(wd.timeout | supply_low_f);
      pf_n_r <= pf_f;
    end
  end

  assign sys_reset_n = sys_reset_n_r;
  assign sys_reset = sys_reset_r;
  assign watchdog_alarm_n = alarm_n_r;
  assign powerfail_flag_n = pf_n_r;

  // ****************************************
  // watchdog
  // ****************************************
  // driven level and floating detect kept apart
  assign wd.tick = tick;
  assign wd.hold = ~sys_reset_n_r;
  assign wd.kick = filt[IN_KICK];
  assign wd.floating = filt[IN_FLOAT];

  ssw_watchdog #(
    .WD_LIMIT(WD_LIMIT),
    .CNT_W(WCNT_W)
  ) u_wdog (
    .mclk(mclk),
    .reset_n(reset_n),
    .wd(wd.wdog)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  supply_holds_a: assert property (supply_low_f |=> !sys_reset_n)
    else $error("reset released while supply low");
  timeout_release_a: assert property ($rose(sys_reset_n) |->
      $past(state_r) == SSW_TIMEOUT && $past(rst_done))
    else $error("reset released before timeout");
  timeout_done_a: assert property (state_r == SSW_TIMEOUT && rst_done && !hold_req
      |=> sys_reset_n)
    else $error("reset not released at timeout");
  reset_inverse_a: assert property (sys_reset == !sys_reset_n)
    else $error("reset outputs not complementary");
  bounce_restart_a: assert property (!mr_n_f |=> state_r == SSW_HOLD && rcnt_r == '0)
    else $error("manual bounce did not restart timeout");
  manual_holds_a: assert property (!mr_n_f |=> !sys_reset_n ##1 !sys_reset_n)
    else $error("manual reset not held");
  lowline_alarm_a: assert property (supply_low_f |=> !watchdog_alarm_n)
    else $error("alarm high during low supply");
  alarm_no_reset_a: assert property (state_r == SSW_RUN && !hold_req |=> sys_reset_n)
    else $error("reset asserted without supply or manual cause");
  alarm_recover_a: assert property ($fell(supply_low_f) && !wd.timeout
      |=> watchdog_alarm_n)
    else $error("alarm not released after supply recovery");
  pf_follow_a: assert property (powerfail_flag_n == $past(pf_f))
    else $error("power-fail flag not following comparator");
  power_on_c: cover property (state_r == SSW_TIMEOUT ##1 state_r == SSW_RUN);
  bounce_c: cover property (state_r == SSW_TIMEOUT ##1 state_r == SSW_HOLD);
  alarm_c: cover property (sys_reset_n && !watchdog_alarm_n && !supply_low_f);
endmodule // ssw_top

/* tb/ssw_cpu_model.sv */
// processor model on the far side: toggles the kick line or lets it float
// assumes the bench starts it only after reset has been released
`timescale 1ns/1ps
module ssw_cpu_model #(
  parameter int KICK_GAP = 60
) (
  input wire logic mclk,
  input wire logic run,
  input wire logic release_line,
  output logic kick,
  output logic floating
);
  // ****************************************
  // kick generator
  // ****************************************
  int gap_cnt = 0;
  initial kick = 1'b0;
  assign floating = release_line;
  always @(posedge mclk) begin
    gap_cnt <= (gap_cnt + 1) % KICK_GAP;
    // a released line wanders every cycle, the watchdog must ignore it
    if (release_line) kick <= #1 ~kick;
    else if (run && gap_cnt == 0) kick <= #1 ~kick;
  end
endmodule // ssw_cpu_model

/* tb/test_supply_supervisor_watchdog.sv */
// self-checking bench for the supply supervisor and its watchdog
// assumes shortened tick, reset and watchdog counts set below
`timescale 1ns/1ps
module test_supply_supervisor_watchdog;
  import ssw_pkg::*;
  // ****************************************
  // set-up
  // ****************************************
  localparam int TC = 4;
  localparam int RL = 5;
  localparam int WL = 20;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic supply_low_in = 1'b1;
  logic manual_reset_n = 1'b1;
  logic powerfail_sense_in = 1'b1;
  logic cpu_run = 1'b0;
  logic cpu_float = 1'b0;
  logic watchdog_kick_in;
  logic watchdog_float_in;
  logic sys_reset_n;
  logic sys_reset;
  logic watchdog_alarm_n;
  logic powerfail_flag_n;
  int n_errors = 0;
  int checked = 0;
  ssw_top #(.TICK_CYC(TC), .RST_LIMIT(RL), .WD_LIMIT(WL)) ssw_top_inst (
    .mclk(mclk), .reset_n(reset_n), .supply_low_in(supply_low_in),
    .manual_reset_n(manual_reset_n), .powerfail_sense_in(powerfail_sense_in),
    .watchdog_kick_in(watchdog_kick_in), .watchdog_float_in(watchdog_float_in),
    .sys_reset_n(sys_reset_n), .sys_reset(sys_reset),
    .watchdog_alarm_n(watchdog_alarm_n), .powerfail_flag_n(powerfail_flag_n)
  );
  ssw_cpu_model ssw_cpu_model_inst (
    .mclk(mclk), .run(cpu_run), .release_line(cpu_float),
    .kick(watchdog_kick_in), .floating(watchdog_float_in)
  );
  initial begin
    forever #50 mclk = ~mclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic wait_release(input int lim);
    for (int i = 0; i < lim && sys_reset_n !== 1'b1; i++) cyc(1);
  endtask
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_on();
    cyc(10);
    check_bit("sys_reset_n", 1'b0, sys_reset_n);
    check_bit("sys_reset", 1'b1, sys_reset);
    check_bit("watchdog_alarm_n", 1'b0, watchdog_alarm_n);
    supply_low_in = 1'b0;
    cyc(RL * TC);
    check_bit("sys_reset_n", 1'b0, sys_reset_n);
    check_bit("watchdog_alarm_n", 1'b1, watchdog_alarm_n);
    wait_release(30);
    check_bit("sys_reset_n", 1'b1, sys_reset_n);
    check_bit("sys_reset", 1'b0, sys_reset);
  endtask
  task automatic t_manual();
    manual_reset_n = 1'b0;
    cyc(8);
    check_bit("sys_reset_n", 1'b0, sys_reset_n);
    manual_reset_n = 1'b1;
    cyc(10);
    // one bounce in the middle of the timeout
    manual_reset_n = 1'b0;
    cyc(3);
    manual_reset_n = 1'b1;
    cyc(RL * TC);
    check_bit("sys_reset_n", 1'b0, sys_reset_n);
    check_bit("sys_reset", 1'b1, sys_reset);
    wait_release(30);
    check_bit("sys_reset_n", 1'b1, sys_reset_n);
  endtask
  task automatic t_watchdog();
    cyc(WL * TC - 10);
    check_bit("watchdog_alarm_n", 1'b1, watchdog_alarm_n);
    for (int i = 0; i < 30 && watchdog_alarm_n !== 1'b0; i++) cyc(1);
    check_bit("watchdog_alarm_n", 1'b0, watchdog_alarm_n);
    check_bit("sys_reset_n", 1'b1, sys_reset_n);
    cyc(2 * WL * TC);
    check_bit("watchdog_alarm_n", 1'b0, watchdog_alarm_n);
    cpu_run = 1'b1;
    cyc(70);
    check_bit("watchdog_alarm_n", 1'b1, watchdog_alarm_n);
    // gap of 15 ticks survives only if both edges clear the timer
    cyc(3 * WL * TC);
    check_bit("watchdog_alarm_n", 1'b1, watchdog_alarm_n);
    cpu_run = 1'b0;
  endtask
  task automatic t_float();
    cpu_float = 1'b1;
    cyc(3 * WL * TC);
    check_bit("watchdog_alarm_n", 1'b1, watchdog_alarm_n);
    supply_low_in = 1'b1;
    cyc(8);
    check_bit("watchdog_alarm_n", 1'b0, watchdog_alarm_n);
    check_bit("sys_reset_n", 1'b0, sys_reset_n);
  endtask
  task automatic t_hold();
    manual_reset_n = 1'b0;
    cpu_float = 1'b0;
    supply_low_in = 1'b0;
    cyc(3 * WL * TC);
    check_bit("watchdog_alarm_n", 1'b1, watchdog_alarm_n);
    manual_reset_n = 1'b1;
    wait_release(40);
    cyc(WL * TC - 10);
    check_bit("watchdog_alarm_n", 1'b1, watchdog_alarm_n);
  endtask
  task automatic t_powerfail();
    powerfail_sense_in = 1'b0;
    cyc(2);
    check_bit("powerfail_flag_n", 1'b1, powerfail_flag_n);
    cyc(6);
    check_bit("powerfail_flag_n", 1'b0, powerfail_flag_n);
    powerfail_sense_in = 1'b1;
    cyc(8);
    check_bit("powerfail_flag_n", 1'b1, powerfail_flag_n);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    cyc(12);
    reset_n = 1'b1;
    t_power_on();
    t_manual();
    t_watchdog();
    t_float();
    t_hold();
    t_powerfail();
    stop_test();
  end
  // the tests need about 1250 cycles, so 3000 means a hang
  initial begin
    #(3000 * 100);
    n_errors++;
    stop_test();
  end
endmodule // test_supply_supervisor_watchdog
